// file: design/lecc_top.sv
// Lane error counter control registers with APB access and counters
`timescale 1ns/100ps
`include "lecc_cfg.svh"
// Register map, byte addresses on the bus
//   Lane 1 to 5 control: four times the printed index, one byte used
//     Bits 7:6 reserved, read zero, writes ignored
//     Bits 5:3 counter enables, bits 2:0 counter clears
//     Bit 2 control char, bit 1 not in table, bit 0 disparity
//   Status: sticky saturation flags, write one to clear
//   Mask: interrupt enables, one bit per counter
//   Counters: read-only windows, one word per counter
// Counter c sits at lane*3 + kind, lane index 0 being lane 1
// Bus timing
//   Zero wait states; read data is caught in the setup cycle
//   Writes land at the access edge of a mapped address
//   Unmapped addresses answer with pslverr and change nothing
//   Lane writes need pstrb[0], since the fields live in byte 0
// Limits
//   Counters saturate rather than wrap, so a flood is never hidden
//   Software reads a count, then clears it through the lane register
//   After reset every counter is held clear until software drops it
//   A count read races a new event by one cycle, as on any live counter
//   Status is set by the saturation pulse and wins over a clear
// Trade-off
//   Read data costs one flop word, but prdata never glitches
//   The interrupt is an AND-OR tree, one level per lane
module lecc_top
  import lecc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        pclk,          // APB clock, 20 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB direction, 1 = write
  input  wire logic [15:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  input  wire logic [3:0]  pstrb,         // APB byte strobes
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error, unmapped address
  input  wire logic [14:0] err_event,     // Error pulses, lane*3 + kind
  output logic      [14:0] counter_enable, // Enable field per lane, flat
  output logic      [14:0] counter_clear,  // Clear field per lane, flat
  output logic             irq             // Level interrupt
);
  localparam int LANES = 5;
  localparam int NCNT  = LANES * 3;

  localparam int FIELD_W = `LECC_ENA_MSB - `LECC_ENA_LSB + 1;

  // Field layout checks, so an edited header cannot scramble a lane word
  if (FIELD_W != 3) begin : g_bad_ena_width
    $error("enable field must be three bits wide");
  end

  if (`LECC_CLR_MSB - `LECC_CLR_LSB != 2) begin : g_bad_clr_width
    $error("clear field must be three bits wide");
  end

  if (`LECC_ENA_LSB != `LECC_CLR_MSB + 1) begin : g_bad_ena_pos
    $error("enable field must sit just above the clear field");
  end

  if (`LECC_RSVD_LSB != `LECC_ENA_MSB + 1) begin : g_bad_rsvd_pos
    $error("reserved bits must sit just above the enable field");
  end

  if (`LECC_RSVD_MSB != 7) begin : g_bad_rsvd_msb
    $error("a lane register is one byte wide");
  end

  // Kind order in the fields must match the package enum
  if (int'(LECC_CTRL_CHAR) != `LECC_BIT_CTRL_CHAR ||
      int'(LECC_NOT_IN_TABLE) != `LECC_BIT_NOT_IN_TABLE ||
      int'(LECC_DISPARITY) != `LECC_BIT_DISPARITY) begin : g_bad_kind_order // [R3]
    $error("kind order differs between package and header");
  end

  // Status and mask take one bit per counter in one data word
  if (NCNT > 32) begin : g_bad_ncnt
    $error("too many counters for one status word");
  end

  // The status window must not overlap the lane registers, nor the counter window the mask
  if (32'(`LECC_CTRL_IDX_L5) * 32'h4 >= 32'(`LECC_STATUS_ADDR)) begin : g_bad_map
    $error("status window overlaps the lane registers");
  end

  if (`LECC_COUNT_BASE < `LECC_MASK_ADDR + 14'h4) begin : g_bad_cnt_base
    $error("counter window overlaps the mask register");
  end

  // Elaboration-time check of the counter width
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must be 2 to 32");
  end

  // Printed indices of the lane registers, lane 1 first
  localparam lecc_index_t CTRL_IDX [LANES] = '{
    `LECC_CTRL_IDX_L1, `LECC_CTRL_IDX_L2, `LECC_CTRL_IDX_L3,
    `LECC_CTRL_IDX_L4, `LECC_CTRL_IDX_L5
  };

  // Lane indices must run on without gaps, lane 1 first
  for (genvar l = 1; l < LANES; l++) begin : g_idx_chk
    if (CTRL_IDX[l] != CTRL_IDX[l-1] + 12'h001) begin : g_gap
      $error("lane register indices must be consecutive");
    end
  end

  // Lane control state
  lecc_field_t ena_r [LANES];
  lecc_field_t clr_r [LANES];

  // Interrupt state
  logic [NCNT-1:0] sts_r;
  logic [NCNT-1:0] sts_nxt;
  logic [NCNT-1:0] mask_r;
  logic [NCNT-1:0] mask_nxt;
  logic [NCNT-1:0] sat_pulse;
  logic [NCNT-1:0] w1c_bits;

  // Counter values
  logic [CNT_W-1:0] cnt [NCNT];

  // Read answer registers, loaded in the setup phase
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // Bus phase decode
  logic        setup_ph;
  logic        access_ph;
  logic        rd_setup;
  logic        xfer_done;
  logic        wr_ok;
  logic [31:0] byte_mask;
  logic [31:0] wdata_m;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // Read data is fetched a cycle early, in the setup cycle
  assign rd_setup  = setup_ph & ~pwrite;
  // A transfer ends at the access edge where ready is high
  assign xfer_done = access_ph & pready;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata_m   = pwdata & byte_mask;

  // Address decode, one select per register
  logic [LANES-1:0] sel_ctrl;
  logic [NCNT-1:0]  sel_cnt;
  logic             sel_sts;
  logic             sel_mask;
  logic             sel_any;

  for (genvar l = 0; l < LANES; l++) begin : g_ctrl_dec
    assign sel_ctrl[l] = (paddr == {2'b00, CTRL_IDX[l], 2'b00});
  end
  // Extra windows widened once to the bus address width
  localparam logic [15:0] STS_ADDR  = 16'(`LECC_STATUS_ADDR);
  localparam logic [15:0] MASK_ADDR = 16'(`LECC_MASK_ADDR);
  localparam logic [15:0] CNT_BASE  = 16'(`LECC_COUNT_BASE);

  for (genvar c = 0; c < NCNT; c++) begin : g_cnt_dec
    assign sel_cnt[c] = (paddr == CNT_BASE + 16'(c * 4));
  end
  assign sel_sts  = (paddr == STS_ADDR);
  assign sel_mask = (paddr == MASK_ADDR);
  assign sel_any  = (|sel_ctrl) | (|sel_cnt) | sel_sts | sel_mask;

  // Writes land only at the completing edge of a mapped access
  assign wr_ok = xfer_done & pwrite & sel_any;

  // Write strobes; lane fields live in byte 0, so pstrb[0] gates them
  logic [LANES-1:0] wr_lane;
  logic             wr_sts;
  logic             wr_mask;
  for (genvar l = 0; l < LANES; l++) begin : g_wr_dec
    assign wr_lane[l] = wr_ok & sel_ctrl[l] & pstrb[0];
  end
  assign wr_sts  = wr_ok & sel_sts;
  assign wr_mask = wr_ok & sel_mask;

  // Per-lane read words; bits 7:6 and the upper bytes are tied low
  logic [31:0] lane_word [LANES];
  for (genvar l = 0; l < LANES; l++) begin : g_lane_word
    assign lane_word[l] = {24'h00_0000, 2'h0, ena_r[l], clr_r[l]}; // [R1] [R2] [R5]
  end

  // Counter read word, zero when no counter is addressed
  logic [31:0] cnt_word;
  always_comb begin
    cnt_word = '0;
    for (int c = 0; c < NCNT; c++) begin
      if (sel_cnt[c]) begin
        cnt_word[CNT_W-1:0] = cnt[c];
      end
    end
  end

  // Read mux as a priority chain; selects are one-hot so order is free
  logic [31:0] rd_mux;
  always_comb begin
    if (sel_ctrl[0]) begin
      rd_mux = lane_word[0];
    end else if (sel_ctrl[1]) begin
      rd_mux = lane_word[1];
    end else if (sel_ctrl[2]) begin
      rd_mux = lane_word[2];
    end else if (sel_ctrl[3]) begin
      rd_mux = lane_word[3];
    end else if (sel_ctrl[4]) begin
      rd_mux = lane_word[4];
    end else if (sel_sts) begin
      rd_mux = {{(32-NCNT){1'b0}}, sts_r};
    end else if (sel_mask) begin
      rd_mux = {{(32-NCNT){1'b0}}, mask_r};
    end else begin
      rd_mux = cnt_word;
    end
  end

  // Answer captured at setup, so prdata comes from a flop at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_setup) begin
      prdata_r <= rd_mux;
    end else if (setup_ph) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // Error decided at setup too, shown only in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= ~sel_any;
    end
  end

  // Zero wait states; the error flag only shows during access
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = access_ph & pslverr_r;

  // Lane control registers; only byte 0 carries fields
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // Enable field; bits 7:6 are never stored, so writes to them vanish
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ena_r[l] <= `LECC_ENA_RESET; // [R4]
      end else if (wr_lane[l]) begin
        ena_r[l] <= pwdata[`LECC_ENA_MSB:`LECC_ENA_LSB]; // [R1] [R5]
      end
    end

    // Clear field; a set bit holds its counter at zero
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        clr_r[l] <= `LECC_CLR_RESET; // [R4]
      end else if (wr_lane[l]) begin
        clr_r[l] <= pwdata[`LECC_CLR_MSB:`LECC_CLR_LSB]; // [R2] [R5]
      end
    end
  end

  // Named lane fields; bit k of a field steers counter kind k of its lane
  logic [2:0] lane1_counter_enable; // Lane 1 enables
  logic [2:0] lane2_counter_enable; // Lane 2 enables
  logic [2:0] lane3_counter_enable; // Lane 3 enables
  logic [2:0] lane4_counter_enable; // Lane 4 enables
  logic [2:0] lane5_counter_enable; // Lane 5 enables
  logic [2:0] lane1_counter_clear;  // Lane 1 clears
  logic [2:0] lane2_counter_clear;  // Lane 2 clears
  logic [2:0] lane3_counter_clear;  // Lane 3 clears
  logic [2:0] lane4_counter_clear;  // Lane 4 clears
  logic [2:0] lane5_counter_clear;  // Lane 5 clears

  // Aliases of the stored fields
  assign lane1_counter_enable = ena_r[0];
  assign lane2_counter_enable = ena_r[1];
  assign lane3_counter_enable = ena_r[2];
  assign lane4_counter_enable = ena_r[3];
  assign lane5_counter_enable = ena_r[4];
  assign lane1_counter_clear  = clr_r[0];
  assign lane2_counter_clear  = clr_r[1];
  assign lane3_counter_clear  = clr_r[2];
  assign lane4_counter_clear  = clr_r[3];
  assign lane5_counter_clear  = clr_r[4];

  // Flat outputs, lane 1 in the low three bits
  assign counter_enable = {lane5_counter_enable, lane4_counter_enable, lane3_counter_enable,
                           lane2_counter_enable, lane1_counter_enable}; // [R3]
  assign counter_clear  = {lane5_counter_clear, lane4_counter_clear, lane3_counter_clear,
                           lane2_counter_clear, lane1_counter_clear};   // [R3]

  // Three counters per lane, kind order disparity, table, control char
  for (genvar c = 0; c < NCNT; c++) begin : g_cnt
    lecc_err_counter #(
      .CNT_W (CNT_W)
    ) u_cnt (
      .clk       (pclk),
      .rst_n     (presetn),
      .enable    (counter_enable[c]), // [R3] [R6]
      .clear     (counter_clear[c]),  // [R3] [R6]
      .event_in  (err_event[c]),
      .count     (cnt[c]),
      .sat_pulse (sat_pulse[c])
    );
  end

  // Sticky status, write one to clear; a new saturation pulse beats the clear
  assign w1c_bits = wr_sts ? wdata_m[NCNT-1:0] : '0;
  assign sts_nxt  = (sts_r & ~w1c_bits) | sat_pulse;

  // Mask keeps the bits whose byte strobe is low
  assign mask_nxt = wr_mask ? ((mask_r & ~byte_mask[NCNT-1:0])
                               | wdata_m[NCNT-1:0]) : mask_r;

  // Status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= '0;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `LECC_MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // Pending sources per lane, so the interrupt tree stays shallow
  logic [LANES-1:0] lane_pend;
  for (genvar l = 0; l < LANES; l++) begin : g_pend
    assign lane_pend[l] = |(sts_r[l*3 +: 3] & mask_r[l*3 +: 3]);
  end

  // Level interrupt, high while any unmasked status bit is set
  assign irq = |lane_pend;
endmodule

// file: design/lecc_cfg.svh
// Constants for the lane error counter control block
// Notes on behaviour
// R1: Each lane register holds a three-bit active-high counter enable field in bits 5:3.
// R2: Each lane register holds a three-bit active-high counter clear field in bits 2:0.
// R3: In both fields bit 2 is control-char, bit 1 not-in-table, bit 0 disparity.
// R4: After reset both fields of every lane read all ones.
// R5: Bits 7:6 of each lane register are read-only, read zero, ignore writes.
// R6: A counter counts only when enabled and not cleared; clear holds it at zero.
`ifndef LECC_CFG_SVH
`define LECC_CFG_SVH

// Printed register indices; byte address is four times the index
`define LECC_CTRL_IDX_L1      12'h481
`define LECC_CTRL_IDX_L2      12'h482
`define LECC_CTRL_IDX_L3      12'h483
`define LECC_CTRL_IDX_L4      12'h484
`define LECC_CTRL_IDX_L5      12'h485

// Status, mask and counter readback byte addresses
`define LECC_STATUS_ADDR      14'h1300
`define LECC_MASK_ADDR        14'h1304
`define LECC_COUNT_BASE       14'h1310

// Field positions inside a lane register
`define LECC_ENA_LSB          3
`define LECC_ENA_MSB          5
`define LECC_CLR_LSB          0
`define LECC_CLR_MSB          2
`define LECC_RSVD_LSB         6
`define LECC_RSVD_MSB         7

// Counter positions inside each field
`define LECC_BIT_DISPARITY    0
`define LECC_BIT_NOT_IN_TABLE 1
`define LECC_BIT_CTRL_CHAR    2

// Reset values
`define LECC_ENA_RESET        3'h7
`define LECC_CLR_RESET        3'h7
`define LECC_MASK_RESET       15'h0000

`endif

// file: design/lecc_pkg.sv
// Types shared by the lane error counter control block
package lecc_pkg;
  // One three-bit field, one bit per error kind
  typedef logic [2:0] lecc_field_t;
  // Error kinds in field bit order
  typedef enum logic [1:0] {
    LECC_DISPARITY    = 2'h0,
    LECC_NOT_IN_TABLE = 2'h1,
    LECC_CTRL_CHAR    = 2'h2
  } lecc_kind_e;
  // Index of a register in the printed map
  typedef logic [11:0] lecc_index_t;
endpackage

// file: design/lecc_err_counter.sv
// One saturating error counter with enable and clear
`timescale 1ns/100ps
module lecc_err_counter #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,       // Block clock
  input  wire logic             rst_n,     // Async reset, active low
  input  wire logic             enable,    // Count permitted
  input  wire logic             clear,     // Hold at zero
  input  wire logic             event_in,  // One error this cycle
  output logic [CNT_W-1:0]      count,     // Current count
  output logic                  sat_pulse  // Pulse on reaching full scale
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             bump;

  // Saturate rather than wrap so a flood of errors is never hidden
  assign bump      = enable & ~clear & event_in & (count_r != CNT_MAX); // [R6]
  assign count_nxt = clear ? '0 : (bump ? count_r + 1'b1 : count_r);   // [R6]
  assign sat_pulse = bump & (count_r == CNT_MAX - 1'b1);
  assign count     = count_r;

  // Count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

// file: test/lecc_checker.sv
// Property checker for the lane error counter control block
`timescale 1ns/100ps
module lecc_checker (
  input wire logic        pclk,           // Clock
  input wire logic        presetn,        // Reset, active low
  input wire logic        psel,           // Select
  input wire logic        penable,        // Access phase
  input wire logic        pwrite,         // Direction
  input wire logic [15:0] paddr,          // Address
  input wire logic [31:0] pwdata,         // Write data
  input wire logic [3:0]  pstrb,          // Strobes
  input wire logic [31:0] prdata,         // Read data
  input wire logic [14:0] counter_enable, // Enable fields
  input wire logic [14:0] counter_clear   // Clear fields
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and effective low-byte write
  wire acc = psel && penable;
  wire wr  = acc && pwrite && pstrb[0];
  a_reset_all_ones: assert property ($rose(presetn) |-> &counter_enable && &counter_clear)
    else $error("fields not all ones after reset");
  a_lane1_enable: assert property (wr && paddr == 16'h1204 |=> counter_enable[2:0] == $past(pwdata[5:3]))
    else $error("lane 1 enable field wrong");
  a_lane1_clear: assert property (wr && paddr == 16'h1204 |=> counter_clear[2:0] == $past(pwdata[2:0]))
    else $error("lane 1 clear field wrong");
  a_lane5_map: assert property (wr && paddr == 16'h1214 |=> counter_enable[14:12] == $past(pwdata[5:3]) && counter_clear[14:12] == $past(pwdata[2:0]))
    else $error("lane 5 fields misplaced");
  // Reserved and upper bits read zero on every lane register
  a_rsvd_read_zero: assert property (acc && !pwrite && paddr >= 16'h1204 && paddr <= 16'h1214 && paddr[1:0] == 2'h0 |-> prdata[31:6] == 26'h0)
    else $error("reserved bits not zero");
  // Fields only move on a write, so stray updates are caught
  a_fields_hold: assert property (!wr |=> $stable(counter_enable) && $stable(counter_clear))
    else $error("field changed without write");
  cover property (wr && paddr == 16'h1204);
  cover property (wr && paddr == 16'h1214);
  cover property (acc && !pwrite && paddr == 16'h1310);
endmodule

// file: test/lecc_top_tb_top.sv
// Self-checking bench for the lane error counter control block
`timescale 1ns/100ps
module lecc_top_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [14:0] err_event = 15'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  wire  [14:0] counter_enable, counter_clear;
  int          n_fail = 0, num_checks = 0;
  int          cnt_exp[3] = '{1, 0, 2};
  always #25 pclk = ~pclk;
  // Small counters so saturation comes quickly
  lecc_top #(.CNT_W(2)) i_lecc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_event(err_event),
    .counter_enable(counter_enable), .counter_clear(counter_clear), .irq(irq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer with an idle cycle after, so no signal is set twice at one edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic hit(input int b, input int n);
    repeat (n) begin
      err_event[b] <= 1; @(posedge pclk);
      err_event[b] <= 0; @(posedge pclk);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Reset values, then a distinct pattern per lane with reserved bits set
    for (int i = 0; i < 5; i++) begin
      apb(0, 16'h1204 + 16'(4 * i), 32'h0); check("lane reset", rd, 32'h3f);
      apb(1, 16'h1204 + 16'(4 * i), 32'hffffffc0 | 32'(i * 9 + 1));
      apb(0, 16'h1204 + 16'(4 * i), 32'h0); check("lane readback", rd, 32'(i * 9 + 1));
      check("enable pins", 32'(counter_enable[3*i+:3]), 32'((i * 9 + 1) >> 3));
      check("clear pins", 32'(counter_clear[3*i+:3]), 32'((i * 9 + 1) & 7));
    end
    // Lane 1 counting: kind 2 twice, kind 0 once
    apb(1, 16'h1204, 32'h38); hit(2, 2); hit(0, 1);
    for (int k = 0; k < 3; k++) begin
      apb(0, 16'h1310 + 16'(4 * k), 32'h0); check("count", rd, 32'(cnt_exp[k]));
    end
    apb(1, 16'h1204, 32'h18); hit(2, 1);
    apb(0, 16'h1318, 32'h0); check("disabled count", rd, 32'h2);
    apb(1, 16'h1204, 32'h1c);
    apb(0, 16'h1318, 32'h0); check("cleared count", rd, 32'h0);
    // Saturation raises status; mask gates the interrupt
    hit(0, 2); check("irq masked", 32'(irq), 32'h0);
    apb(1, 16'h1304, 32'h1); check("irq on", 32'(irq), 32'h1);
    apb(0, 16'h1300, 32'h0); check("status", rd, 32'h1);
    apb(1, 16'h1300, 32'h1); check("irq off", 32'(irq), 32'h0);
    apb(0, 16'h1200, 32'h0); check("unmapped err", 32'(err), 32'h1);
    give_verdict;
  end
  initial begin
    #100us;
    n_fail++;
    give_verdict;
  end
endmodule
bind lecc_top lecc_checker i_lecc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .counter_enable(counter_enable), .counter_clear(counter_clear));
